// ### rtl/lct_capture.sv
// Capture and trigger control with ring store and output skid buffer
// Operation
// - Trigger on high level, low level, rising edge or falling edge.
// - One trigger mode at a time; none selected means untriggered start.
// - Position 100 percent stops at trigger, keeps samples before it.
// - Position 0 percent stores the full count after the trigger.
// - Middle positions split stored samples before and after trigger.
// - Triggered capture ends once trigger seen and post samples stored.
// - Sample all channels at set rate until the sample count is met; counts above the ring depth of 1024 stop at 1024 samples.
// - With no trigger mode, recording starts on the start command.
// - Cancel stops recording at once, whatever the progress.
// - Start with a trigger mode arms; sample while watching trigger.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module lct_capture
  import lct_pkg::*;
#(
  parameter int CHW = 4,
  parameter int AW  = 10,
  parameter int CW  = 21
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // Register port
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [31:0]      rdata,
  // Probe inputs
  input  wire logic [2**CHW-1:0] ch_in,
  // Sample stream out
  output logic      [2**CHW-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int NCH = 2**CHW;
  localparam logic [CW-1:0] DEPTH_C = CW'(2**AW);

  typedef enum {S_IDLE, S_ARMED, S_POST, S_DUMP} lct_state_type;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  lct_state_type    st_q, st_d;
  logic [2:0]       mode_q;
  logic [CHW-1:0]   chs_q;
  logic [2:0]       pos_q;
  logic [15:0]      div_q, dcnt_q;
  logic [CW-1:0]    count_q, filled_q, left_q;
  logic [NCH-1:0]   s1_q, s2_q, s3_q, filt_q;
  logic             prev_q, trig_q, done_q, canc_q;
  logic [AW-1:0]    wp_q, rp_q;
  logic [NCH-1:0]   mem [2**AW];
  logic             ov_q, sv_q;
  logic [NCH-1:0]   od_q, sd_q;
  logic [31:0]      rdata_q;

  // ---------------------------------------------------------------
  // Decode and datapath
  // ---------------------------------------------------------------
  wire wr_ctrl = wr && (addr == OFS_CTRL);
  wire do_start = wr_ctrl && wdata[B_START] && (st_q == S_IDLE);
  wire do_cancel = wr_ctrl && wdata[B_CANCEL] && (st_q != S_IDLE);
  wire cfg_ok = wr && (st_q == S_IDLE);
  wire [CW-1:0] eff = (count_q > DEPTH_C) ? DEPTH_C : count_q;
  wire [2:0] pos_c = (pos_q > POS_MAX) ? POS_MAX : pos_q;
  wire [CW+2:0] prod = (CW+3)'(eff) * (CW+3)'(pos_c);
  wire [CW-1:0] pre_w = CW'(prod >> POS_SHIFT);
  wire [CW-1:0] post_w = eff - pre_w;
  wire cur = filt_q[chs_q];
  wire hit = lct_hit(mode_q, cur, prev_q);
  wire tick = (dcnt_q >= div_q);
  wire pre_ok = (filled_q >= pre_w);
  wire fire = (st_q == S_ARMED) && tick && hit && pre_ok;
  wire sampling = (st_q == S_ARMED) || (st_q == S_POST);
  // Post phase over: no extra sample may slip in before the dump
  wire post_end = (st_q == S_POST) && (left_q == '0);
  wire store = sampling && tick && !fire && !do_cancel && !post_end;
  wire in_rdy = !sv_q;
  wire emit = (st_q == S_DUMP) && (left_q != '0) && in_rdy;
  wire [NCH-1:0] rd_word = mem[rp_q];
  wire [NCH-1:0] s_agree = ~(s2_q ^ s3_q);
  wire [NCH-1:0] filt_d = (s_agree & s3_q) | (~s_agree & filt_q);
  wire lct_stat_type stat = '{canc_q, done_q, trig_q,
                              st_q == S_ARMED, st_q != S_IDLE};

  // Register read selection
  wire [31:0] rd_val =
    (addr == OFS_TRIG)  ? {20'h0_0000, 4'(chs_q), 5'h00, mode_q} :
    (addr == OFS_POS)   ? {29'h0000_0000, pos_q} :
    (addr == OFS_DIV)   ? {16'h0000, div_q} :
    (addr == OFS_COUNT) ? 32'(count_q) :
    (addr == OFS_STAT)  ? 32'(stat) : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Next state of the capture sequence
  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (do_start) begin
          st_d = (mode_q == MODE_NONE) ? S_POST : S_ARMED;
        end
      end
      S_ARMED: begin
        // stop at trigger when no post samples
        if (fire) begin
          st_d = (post_w == '0) ? S_DUMP : S_POST;
        end
      end
      S_POST: begin
        if (left_q == '0) begin
          st_d = S_DUMP;
        end
      end
      S_DUMP: begin
        if (left_q == '0) begin
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (do_cancel) begin
      st_d = S_IDLE;
    end
  end

  // State, counters and pointers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      dcnt_q <= '0;
      filled_q <= '0;
      left_q <= '0;
      wp_q <= '0;
      rp_q <= '0;
      prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      dcnt_q <= (tick || do_start) ? '0 : dcnt_q + 16'h0001;
      if (do_start || tick) begin
        prev_q <= cur;
      end
      if (do_start) begin
        filled_q <= '0;
        left_q <= eff;
      end else if (fire) begin
        // post count loaded at trigger, full dump if none
        left_q <= (post_w == '0) ? eff : post_w;
      end else if (store && st_q == S_POST) begin
        left_q <= left_q - CW'(1);
      end else if (st_q == S_POST && left_q == '0) begin
        left_q <= eff;
      end else if (emit) begin
        left_q <= left_q - CW'(1);
      end
      if (store && filled_q != DEPTH_C) begin
        filled_q <= filled_q + CW'(1);
      end
      if (store) begin
        wp_q <= wp_q + AW'(1);
      end
      if (st_q == S_POST && left_q == '0) begin
        rp_q <= wp_q - AW'(eff);
      end else if (st_q == S_ARMED && st_d == S_DUMP) begin
        rp_q <= wp_q - AW'(eff);
      end else if (emit) begin
        rp_q <= rp_q + AW'(1);
      end
    end
  end

  // Sample ring, written on each stored tick
  always_ff @(posedge clock) begin
    if (store) begin
      mem[wp_q] <= filt_q;
    end
  end

  // Probe synchroniser with agreement filter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= ch_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Configuration writes, taken only while idle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_NONE;
      chs_q <= '0;
      pos_q <= '0;
      div_q <= DIV_RST;
      count_q <= CW'(COUNT_RST);
    end else if (cfg_ok) begin
      // single mode field, bad codes mean none
      if (addr == OFS_TRIG) begin
        mode_q <= (wdata[2:0] > MODE_FALL) ? MODE_NONE : wdata[2:0];
        chs_q <= wdata[TRIG_CH_LSB +: CHW];
      end
      if (addr == OFS_POS) begin
        pos_q <= wdata[2:0];
      end
      if (addr == OFS_DIV) begin
        div_q <= wdata[15:0];
      end
      if (addr == OFS_COUNT) begin
        count_q <= wdata[CW-1:0];
      end
    end
  end

  // Status flags and read data
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trig_q <= 1'b0;
      done_q <= 1'b0;
      canc_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      rdata_q <= rd ? rd_val : 32'h0000_0000;
      if (do_start) begin
        trig_q <= 1'b0;
        done_q <= 1'b0;
        canc_q <= 1'b0;
      end
      if (fire) begin
        trig_q <= 1'b1;
      end
      if (st_q == S_DUMP && left_q == '0) begin
        done_q <= 1'b1;
      end
      if (do_cancel) begin
        canc_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Two-entry skid buffer toward the host stream
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ov_q <= 1'b0;
      sv_q <= 1'b0;
      od_q <= '0;
      sd_q <= '0;
    end else if (out_ready || !ov_q) begin
      ov_q <= sv_q || emit;
      od_q <= sv_q ? sd_q : rd_word;
      sv_q <= sv_q && emit;
      sd_q <= rd_word;
    end else if (emit) begin
      sv_q <= 1'b1;
      sd_q <= rd_word;
    end
  end

  assign rdata = rdata_q;
  assign out_data = od_q;
  assign out_valid = ov_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_high_level: assert property (@(posedge clock) disable iff (!rstn)
    st_q == S_ARMED && mode_q == MODE_HIGH && tick && cur && pre_ok
    && !do_cancel |=> st_q != S_ARMED && trig_q)
    else $error("high level missed");
  a_mode_single: assert property (@(posedge clock) disable iff (!rstn)
    mode_q <= MODE_FALL)
    else $error("bad trigger mode");
  a_stop_full: assert property (@(posedge clock) disable iff (!rstn)
    fire && post_w == '0 && !do_cancel
    |=> st_q == S_DUMP && left_q == $past(eff))
    else $error("no stop at trigger");
  a_post_load: assert property (@(posedge clock) disable iff (!rstn)
    fire && post_w != '0 && !do_cancel
    |=> st_q == S_POST && left_q == $past(post_w))
    else $error("post count wrong");
  a_pre_share: assert property (@(posedge clock) disable iff (!rstn)
    fire |-> filled_q >= pre_w && pre_w + post_w == eff)
    else $error("pre share wrong");
  a_post_end: assert property (@(posedge clock) disable iff (!rstn)
    st_q == S_POST && store && left_q == CW'(1) && !do_cancel
    |=> left_q == '0 ##1 (st_q == S_DUMP || canc_q))
    else $error("post end missed");
  a_rate_gap: assert property (@(posedge clock) disable iff (!rstn)
    tick && div_q != '0 && !do_start |=> !tick && !store)
    else $error("store off rate");
  a_start_free: assert property (@(posedge clock) disable iff (!rstn)
    do_start && mode_q == MODE_NONE && !do_cancel
    |=> st_q == S_POST && left_q == $past(eff))
    else $error("untriggered start");
  a_cancel_stop: assert property (@(posedge clock) disable iff (!rstn)
    do_cancel |=> st_q == S_IDLE && canc_q && !store)
    else $error("cancel ignored");
  a_start_arm: assert property (@(posedge clock) disable iff (!rstn)
    do_start && mode_q != MODE_NONE |=> st_q == S_ARMED && !trig_q)
    else $error("arm failed");
  a_edge_rise: assert property (@(posedge clock) disable iff (!rstn)
    fire && mode_q == MODE_RISE |-> cur && !prev_q)
    else $error("edge wrong");
endmodule : lct_capture

// ### rtl/lct_pkg.sv
// Package: register map, field layout and reset values of capture control
package lct_pkg;
  // ---------------------------------------------------------------
  // Clock and default sample rate
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ  = 32'h0BEB_C200;
  localparam int unsigned RATE_HZ = 32'h0003_D090;
  localparam logic [15:0] DIV_RST = 16'(CLK_HZ / RATE_HZ - 1);
  localparam int unsigned COUNT_RST = 32'h0000_0400;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_TRIG  = 8'h04;
  localparam logic [7:0] OFS_POS   = 8'h08;
  localparam logic [7:0] OFS_DIV   = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;

  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int B_START     = 0;
  localparam int B_CANCEL    = 1;
  localparam int TRIG_CH_LSB = 8;
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_HIGH = 3'h1;
  localparam logic [2:0] MODE_LOW  = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_FALL = 3'h4;
  localparam logic [2:0] POS_MAX   = 3'h4;
  localparam int POS_SHIFT = 2;

  // Status word, low bits of the status register
  typedef struct packed {
    logic cancelled;
    logic done;
    logic triggered;
    logic armed;
    logic busy;
  } lct_stat_type;

  // Trigger match: levels look at one sample, edges at two
  function automatic logic lct_hit(logic [2:0] m, logic cur, logic prv);
    case (m)
      MODE_HIGH: lct_hit = cur;
      MODE_LOW:  lct_hit = !cur;
      MODE_RISE: lct_hit = cur && !prv;
      MODE_FALL: lct_hit = !cur && prv;
      default:   lct_hit = 1'b0;
    endcase
  endfunction : lct_hit
endpackage : lct_pkg

// ### verif/lct_host_sink.sv
// Host side sink model that takes dumped sample words
`timescale 1ns/10ps
module lct_host_sink (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Pace control and stream handshake
  input  wire logic slow,
  output logic      out_ready
);
  logic [1:0] ph_q;
  // Free running phase; slow pace takes one word in four
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
    end
  end
  assign out_ready = !slow || (ph_q == 2'h3);
endmodule : lct_host_sink

// ### verif/lct_capture_tb.sv
// Self-checking bench for capture and trigger control
`timescale 1ns/10ps
module lct_capture_tb;
  import lct_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] ch_in = 16'h0000;
  logic [15:0] out_data;
  logic        out_valid;
  logic        out_ready;
  logic        slow = 1'b0;
  logic [31:0] rng = 32'h0001_0A38;
  logic [15:0] got[$];
  logic [15:0] exp_q[$];
  int          n_errors = 0;
  int          check_count = 0;
  // Level pattern of trigger bit in phases A, M, B per mode
  logic [2:0]  pat [1:4] = '{3'h1, 3'h6, 3'h5, 3'h2};

  lct_capture i_lct_capture (.clock(clock), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ch_in(ch_in),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
  lct_host_sink i_lct_host_sink (.clock(clock), .rstn(rstn), .slow(slow),
    .out_ready(out_ready));

  // Clock and stream monitor
  always #2.5 clock = !clock;
  always @(posedge clock) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Xorshift source of random probe words
  function automatic logic [15:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[15:0];
  endfunction : nxt

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rreg(a, d);
    chk("reg", e, d);
  endtask : rchk

  // Poll status until done, then compare the dumped words
  task automatic finish_cap(output logic [31:0] s);
    int k;
    k = 0;
    s = 32'h0000_0000;
    while (s[3] !== 1'b1 && k < 500) begin
      rreg(OFS_STAT, s);
      k++;
    end
    chk("done", 32'h1, {31'h0, s[3]});
    // Up to two words may still sit in the output buffer
    repeat (12) @(posedge clock);
    chk("count", 32'(exp_q.size()), 32'(got.size()));
    foreach (exp_q[i]) begin
      if (i < got.size()) chk("word", exp_q[i], got[i]);
    end
    got.delete();
    exp_q.delete();
  endtask : finish_cap

  initial begin
    #300000;
    n_errors++;
    close_out();
  end

  initial begin
    logic [15:0] va, vm, vb;
    logic [31:0] s;
    int          c, pre;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    // ---------------------------------------------------------------
    // Reset values and unmapped read
    // ---------------------------------------------------------------
    rchk(OFS_TRIG, 32'h0000_0000);
    rchk(OFS_POS, 32'h0000_0000);
    rchk(OFS_DIV, 32'(DIV_RST));
    rchk(OFS_COUNT, COUNT_RST);
    rchk(8'h18, 32'h0000_0000);
    wreg(OFS_DIV, 32'h0000_0001);
    wreg(OFS_COUNT, 32'h0000_0008);
    // Untriggered capture after a mode is selected then cleared
    wreg(OFS_TRIG, 32'(MODE_HIGH));
    wreg(OFS_TRIG, 32'(MODE_NONE));
    va = nxt();
    ch_in <= va;
    slow <= 1'b1;
    repeat (6) @(posedge clock);
    wreg(OFS_CTRL, 32'h0000_0001);
    rreg(OFS_STAT, s);
    chk("busy", 32'h1, {31'h0, s[0]});
    repeat (8) exp_q.push_back(va);
    finish_cap(s);
    $display("test untriggered ended");
    // Every mode against every position, with stalls on odd modes
    for (int md = 1; md <= 4; md++) begin
      for (int p = 0; p <= 4; p++) begin
        va = nxt();
        vm = nxt();
        vb = nxt();
        c = vb[11:8];
        va[c] = pat[md][2];
        vm[c] = pat[md][1];
        vb[c] = pat[md][0];
        slow <= md[0];
        wreg(OFS_TRIG, {20'h0, 4'(c), 5'h0, 3'(md)});
        wreg(OFS_POS, 32'(p));
        ch_in <= va;
        repeat (8) @(posedge clock);
        wreg(OFS_CTRL, 32'h0000_0001);
        repeat (40) @(posedge clock);
        ch_in <= vm;
        repeat (40) @(posedge clock);
        ch_in <= vb;
        pre = (8 * p) >> 2;
        for (int i = 0; i < 8; i++) exp_q.push_back(i < pre ? vm : vb);
        finish_cap(s);
        chk("triggered", 32'h1, {31'h0, s[2]});
      end
    end
    $display("test triggered ended");
    // Cancel a long untriggered capture
    slow <= 1'b0;
    wreg(OFS_TRIG, 32'h0000_0000);
    wreg(OFS_COUNT, 32'h0000_0400);
    wreg(OFS_CTRL, 32'h0000_0001);
    repeat (20) @(posedge clock);
    wreg(OFS_CTRL, 32'h0000_0002);
    rreg(OFS_STAT, s);
    chk("cancel", 32'h0000_0010, s & 32'h0000_0011);
    repeat (100) @(posedge clock);
    chk("after cancel", 32'h0, 32'(got.size()));
    $display("test cancel ended");
    close_out();
  end
endmodule : lct_capture_tb
